// ### logic/gpa_cfg.svh
`ifndef GPA_CFG_SVH
`define GPA_CFG_SVH
// Grant status codes.
`define GPA_ST_READ_HI 3'h0
`define GPA_ST_READ_LO 3'h1
`define GPA_ST_WRITE_LO 3'h2
`define GPA_ST_REQUEST 3'h7
`define GPA_ST_IDLE 3'h7
// Request response window for a port-aware master, in clocks after grant.
`define GPA_PORT_WINDOW 4'h2
// Idle-clock allowance for a plain PCI master.
`define GPA_PCI_WINDOW 5'h10
// Clocks that the pin synchroniser adds before the state machine sees a pin.
`define GPA_SYNC_LATENCY 5'h02
`define GPA_TARGET_WINDOW 2'h2
`endif

// ### logic/gpa_pkg.sv
package gpa_pkg;
  typedef enum logic [2:0] {
    GPA_IDLE = 3'b000,
    GPA_REQ_GNT = 3'b001,
    GPA_DATA_GNT = 3'b010,
    GPA_PIPE_BUSY = 3'b011,
    GPA_DEAD = 3'b100
  } gpa_state_type;
  // Sampled active-high view of the master's bus signals.
  typedef struct packed {
    logic req;
    logic frame;
    logic pipe;
    logic irdy;
  } gpa_bus_in_type;
  // Core side data-grant request.
  typedef struct packed {
    logic valid;
    logic write;
    logic high_pri;
  } gpa_data_req_type;
endpackage

// ### logic/gpa_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for the master's pins.
module gpa_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage <= '0;
      q <= '0;
    end else begin
      stage <= d;
      q <= stage;
    end
  end
endmodule

// ### logic/gpa_arbiter.sv
`timescale 1ns/1ps
`include "gpa_cfg.svh"
// Function
// [R1] Master asserts request when it needs a PCI cycle or pipelined requests.
// [R2] Master drops request one clock before dropping the pipelined strobe.
// [R3] Request low with strobe high marks last request; next grant may follow.
// [R4] Master leaves request low one clock between back-to-back pipe bursts.
// [R5] Master should combine many address requests into one pipe burst.
// [R6] Master drops request with frame unless another request is pending.
// [R7] Sideband-configured master never issues pipelined requests on AD.
// [R8] Grant starts activity; status code meaningful only while grant asserted.
// [R9] Request grant holds until frame or pipelined strobe sampled asserted.
// [R10] Master asserts frame or strobe one or two clocks after grant.
// [R11] Missing response within window lets arbiter withdraw grant, mark dead.
// [R12] Plain PCI master is inoperative only after 16 idle clocks.
// [R13] Read or write data grant lasts exactly one clock.
// [R14] Code 111 grants PCI cycle or pipe request until frame or strobe.
// [R15] Code 00x grants read data; master accepts from next edge.
// [R16] Target asserts TRDY and drives read data one or two clocks later.
// [R17] Code 010 grants write data; target accepts from next clock.
// [R18] Master asserts IRDY and drives write data one or two clocks later.
// [R19] Master accepts pipelined grants for back-to-back data.
// [R20] Grant drops the clock after frame or strobe is sampled.
module gpa_arbiter
  import gpa_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Master pins, active low, asynchronous to the core
  input wire logic req_n,
  input wire logic frame_n,
  input wire logic pipe_n,
  input wire logic irdy_n,
  // Configuration
  input wire logic plain_pci_master,
  input wire logic sideband_address_port,
  // Core requests for data grants
  input wire gpa_data_req_type data_req,
  output logic data_req_taken,
  // Target read engine start
  output logic read_start,
  // Arbiter pins
  output logic gnt_n,
  output logic [2:0] grant_status_code,
  // Status
  output logic master_dead
);
  gpa_bus_in_type bus;
  gpa_state_type state;
  gpa_state_type next_state;
  logic [4:0] wait_count;
  logic [4:0] next_wait_count;
  logic [2:0] next_code;
  logic next_gnt;
  logic next_taken;
  logic next_read_start;

  gpa_sync #(
    .WIDTH(4)
  ) i_gpa_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({~req_n, ~frame_n, ~pipe_n, ~irdy_n}),
    .q(bus)
  );

  function automatic logic [2:0] data_code(input gpa_data_req_type r);
    if (r.write) begin
      data_code = `GPA_ST_WRITE_LO;
    end else if (r.high_pri) begin
      data_code = `GPA_ST_READ_HI;
    end else begin
      data_code = `GPA_ST_READ_LO;
    end
  endfunction

  wire started = bus.frame | (bus.pipe & ~sideband_address_port);
  // The pins reach the state machine two clocks late, so each response
  // window is stretched by the synchroniser depth; without this a master
  // that answers on time would be declared dead.
  wire [4:0] window = (plain_pci_master ? `GPA_PCI_WINDOW :
                      {1'b0, `GPA_PORT_WINDOW}) + `GPA_SYNC_LATENCY;
  wire timed_out = (wait_count >= window);
  // The last request of a burst is flagged by request low with strobe high.
  wire pipe_last = bus.pipe & ~bus.req;
  wire bus_free = ~bus.frame & ~bus.irdy & ~bus.pipe;

  always_comb begin
    next_state = state;
    next_wait_count = wait_count;
    next_code = `GPA_ST_IDLE;
    next_gnt = 1'b0;
    next_taken = 1'b0;
    next_read_start = 1'b0;
    case (state)
      GPA_IDLE: begin
        next_wait_count = '0;
        if (data_req.valid) begin
          next_gnt = 1'b1; // R8
          next_code = data_code(data_req); // R15 R17
          next_taken = 1'b1;
          next_read_start = ~data_req.write; // R16
          next_state = GPA_DATA_GNT;
        end else if (bus.req && bus_free) begin
          next_gnt = 1'b1;
          next_code = `GPA_ST_REQUEST; // R14
          next_state = GPA_REQ_GNT;
        end
      end
      GPA_REQ_GNT: begin
        if (started) begin
          next_state = bus.pipe ? GPA_PIPE_BUSY : GPA_IDLE; // R20
        end else if (timed_out) begin
          next_state = GPA_DEAD; // R11 R12
        end else begin
          next_gnt = 1'b1; // R9
          next_code = `GPA_ST_REQUEST;
          next_wait_count = wait_count + 5'h01;
        end
      end
      GPA_DATA_GNT: begin
        next_state = GPA_IDLE; // R13
      end
      GPA_PIPE_BUSY: begin
        // Data grants may be issued from IDLE on the clock after the last request is flagged.
        if (pipe_last || !bus.pipe) begin // R3
          next_state = GPA_IDLE;
        end
      end
      GPA_DEAD: begin
        next_state = GPA_DEAD;
      end
      default: begin
        next_state = GPA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= GPA_IDLE;
      wait_count <= '0;
      gnt_n <= 1'b1;
      grant_status_code <= `GPA_ST_IDLE;
      data_req_taken <= 1'b0;
      read_start <= 1'b0;
      master_dead <= 1'b0;
    end else begin
      state <= next_state;
      wait_count <= next_wait_count;
      gnt_n <= ~next_gnt;
      grant_status_code <= next_code;
      data_req_taken <= next_taken;
      read_start <= next_read_start;
      master_dead <= (next_state == GPA_DEAD);
    end
  end

  property p_data_one_clock;
    @(posedge clock) disable iff (!rst_n)
    (!gnt_n && grant_status_code != `GPA_ST_REQUEST) |=> gnt_n;
  endproperty
  a_data_one_clock: assert property (p_data_one_clock) // R13
    else $error("data grant held longer than one clock");

  property p_hold_until_start;
    @(posedge clock) disable iff (!rst_n)
    (state == GPA_REQ_GNT && !started && !timed_out) |=> !gnt_n;
  endproperty
  a_hold_until_start: assert property (p_hold_until_start) // R9
    else $error("request grant dropped before frame or strobe");

  property p_drop_after_start;
    @(posedge clock) disable iff (!rst_n)
    (state == GPA_REQ_GNT && started) |=> gnt_n;
  endproperty
  a_drop_after_start: assert property (p_drop_after_start) // R20
    else $error("grant not dropped after start sampled");

  property p_req_code;
    @(posedge clock) disable iff (!rst_n)
    (state == GPA_REQ_GNT) |->
      !gnt_n && grant_status_code == `GPA_ST_REQUEST;
  endproperty
  a_req_code: assert property (p_req_code) // R14
    else $error("request grant without code 111");

  property p_dead_timeout;
    @(posedge clock) disable iff (!rst_n)
    $rose(master_dead) |-> $past(wait_count) >= $past(window);
  endproperty
  a_dead_timeout: assert property (p_dead_timeout) // R11
    else $error("master declared dead too early");

  property p_pci_sixteen;
    @(posedge clock) disable iff (!rst_n)
    ($rose(master_dead) && plain_pci_master) |->
      $past(wait_count) == `GPA_PCI_WINDOW + `GPA_SYNC_LATENCY;
  endproperty
  a_pci_sixteen: assert property (p_pci_sixteen) // R12
    else $error("plain master not given sixteen clocks");

  property p_dead_no_grant;
    @(posedge clock) disable iff (!rst_n)
    master_dead |-> gnt_n;
  endproperty
  a_dead_no_grant: assert property (p_dead_no_grant) // R11
    else $error("grant while master dead");

  property p_read_code;
    @(posedge clock) disable iff (!rst_n)
    read_start |-> !gnt_n && grant_status_code[2:1] == 2'b00;
  endproperty
  a_read_code: assert property (p_read_code) // R15
    else $error("read start without 00x grant");

  property p_write_code;
    @(posedge clock) disable iff (!rst_n)
    (data_req_taken && !read_start) |->
      grant_status_code == `GPA_ST_WRITE_LO;
  endproperty
  a_write_code: assert property (p_write_code) // R17
    else $error("write grant without code 010");

  property p_last_frees;
    @(posedge clock) disable iff (!rst_n)
    (state == GPA_PIPE_BUSY && pipe_last) |=> state == GPA_IDLE;
  endproperty
  a_last_frees: assert property (p_last_frees) // R3
    else $error("last request not used to free arbiter");
endmodule

// ### sim/gpa_master.sv
`timescale 1ns/1ps
// Behavioural graphics bus master; released strobes sit at the pull-up level.
module gpa_master (
  // Clock
  input wire logic clock,
  // Arbiter pins
  input wire logic gnt_n,
  input wire logic [2:0] grant_status_code,
  // Bench control
  input wire logic go,
  input wire logic use_pipe,
  input wire logic [5:0] delay,
  // Master pins
  output logic req_n,
  output logic frame_n,
  output logic pipe_n,
  output logic irdy_n
);
  initial begin
    {req_n, frame_n, pipe_n, irdy_n} = 4'hf;
  end
  always begin
    @(posedge clock);
    if (!gnt_n && grant_status_code === 3'h2) begin
      irdy_n <= 1'b0;
      @(posedge clock);
      irdy_n <= 1'b1;
    end
    if (go && req_n) begin
      req_n <= 1'b0;
    end
    if (!req_n && !gnt_n && grant_status_code === 3'h7) begin
      repeat (delay) @(posedge clock);
      if (use_pipe) begin
        pipe_n <= 1'b0;
        @(posedge clock);
        req_n <= 1'b1;
        @(posedge clock);
        pipe_n <= 1'b1;
      end else begin
        frame_n <= 1'b0;
        req_n <= 1'b1;
        @(posedge clock);
        frame_n <= 1'b1;
      end
    end
  end
endmodule

// ### sim/graphics_port_req_gnt_arbitration_bench.sv
`timescale 1ns/1ps
module graphics_port_req_gnt_arbitration_bench
  import gpa_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic plain = 1'b0;
  logic go = 1'b0;
  logic use_pipe = 1'b0;
  logic [5:0] delay = 6'h0;
  gpa_data_req_type data_req = '0;
  logic req_n, frame_n, pipe_n, irdy_n, taken, rd_start, gnt_n, dead;
  logic [2:0] code;
  int mismatches = 0;
  int samples_checked = 0;
  always #2 clock = ~clock;
  gpa_arbiter i_gpa_arbiter (.clock(clock), .rst_n(rst_n), .req_n(req_n),
    .frame_n(frame_n), .pipe_n(pipe_n), .irdy_n(irdy_n),
    .plain_pci_master(plain), .sideband_address_port(1'b0),
    .data_req(data_req), .data_req_taken(taken), .read_start(rd_start),
    .gnt_n(gnt_n), .grant_status_code(code), .master_dead(dead));
  gpa_master i_gpa_master (.clock(clock), .gnt_n(gnt_n),
    .grant_status_code(code), .go(go), .use_pipe(use_pipe), .delay(delay),
    .req_n(req_n), .frame_n(frame_n), .pipe_n(pipe_n), .irdy_n(irdy_n));
  task automatic end_of_test;
    $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  task automatic wait_gnt;
    int n;
    n = 0;
    while (gnt_n !== 1'b0) begin
      tick();
      n++;
      if (n > 60) begin
        chk("grant wait", 8'h0, 8'h1);
        end_of_test();
      end
    end
  endtask
  task automatic do_reset(input logic pci);
    @(posedge clock);
    rst_n <= 1'b0;
    plain <= pci;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    tick();
  endtask
  task automatic t_data(input logic wr, input logic hi, input logic [2:0] c);
    @(posedge clock);
    data_req <= '{valid: 1'b1, write: wr, high_pri: hi};
    #1;
    wait_gnt();
    chk("data taken", 8'h1, {7'h0, taken});
    chk("data code", {5'h0, c}, {5'h0, code});
    chk("read start", {7'h0, ~wr}, {7'h0, rd_start});
    @(posedge clock);
    data_req <= '0;
    #1;
    chk("data grant end", 8'h1, {7'h0, gnt_n});
    $display("Data grant test done, code %h", c);
  endtask
  task automatic t_req(input logic pipe, input logic [5:0] dly);
    int len;
    @(posedge clock);
    use_pipe <= pipe;
    delay <= dly;
    go <= 1'b1;
    #1;
    wait_gnt();
    chk("request code", 8'h7, {5'h0, code});
    @(posedge clock);
    go <= 1'b0;
    #1;
    len = 1;
    while (gnt_n === 1'b0 && len < 20) begin
      tick();
      len++;
    end
    chk("grant hold", 8'h1, {7'h0, len >= dly + 3 && len <= dly + 5});
    chk("alive", 8'h0, {7'h0, dead});
    $display("Request test done, pipe %b delay %0d", pipe, dly);
  endtask
  task automatic t_dead(input logic pci, input logic [5:0] dly, input logic d);
    int grants;
    do_reset(pci);
    t_data(1'b1, 1'b1, 3'h2);
    @(posedge clock);
    use_pipe <= 1'b0;
    delay <= dly;
    go <= 1'b1;
    #1;
    wait_gnt();
    @(posedge clock);
    go <= 1'b0;
    repeat (40) tick();
    chk("inoperative", {7'h0, d}, {7'h0, dead});
    chk("grant withdrawn", 8'h1, {7'h0, gnt_n});
    @(posedge clock);
    data_req <= '{valid: 1'b1, write: 1'b1, high_pri: 1'b0};
    // Data grants last one clock, so count them over the whole window.
    grants = 0;
    repeat (6) begin
      tick();
      if (gnt_n === 1'b0) grants++;
    end
    chk("refused", {7'h0, ~d}, {7'h0, grants > 0});
    @(posedge clock);
    data_req <= '0;
    repeat (3) tick();
    $display("Inoperative test done, plain %b delay %0d", pci, dly);
  endtask
  initial begin
    do_reset(1'b0);
    t_data(1'b1, 1'b0, 3'h2);
    t_data(1'b0, 1'b1, 3'h0);
    t_data(1'b0, 1'b0, 3'h1);
    t_req(1'b0, 6'h0);
    t_req(1'b0, 6'h1);
    t_req(1'b1, 6'h0);
    t_req(1'b1, 6'h1);
    t_dead(1'b0, 6'h6, 1'b1);
    t_dead(1'b1, 6'ha, 1'b0);
    t_dead(1'b1, 6'h1e, 1'b1);
    end_of_test();
  end
endmodule
